// File: i2c_pkg.sv
package i2c_pkg;
	// Register byte offsets
	localparam logic [3:0] OFF_CTRL = 4'h0;
	localparam logic [3:0] OFF_BUF  = 4'h4;
	localparam logic [3:0] OFF_RATE = 4'h8;
	localparam logic [3:0] OFF_STAT = 4'hC;
	// Field positions in control_reg_two
	localparam int B_START   = 0;
	localparam int B_RESTART = 1;
	localparam int B_STOP    = 2;
	localparam int B_RECV    = 3;
	localparam int B_ACKDATA = 5;
	localparam int B_ACKSTAT = 6;
	// Write-one-to-clear bits of port_status_reg
	localparam logic [2:0] STAT_W1C = 3'h7;
	// Reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [6:0] RATE_RST = 7'h18;
	localparam logic [7:0] BUF_RST  = 8'h00;
	// Instruction cycle phases; counter ticks on phase_two and phase_four
	localparam logic [1:0] PHASE_TWO  = 2'h1;
	localparam logic [1:0] PHASE_FOUR = 2'h3;
	// Bits per byte, which is also the index of the acknowledge slot
	localparam logic [3:0] ACK_SLOT = 4'h8;
	// Bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [4:0] {
		st_idle, st_setup, st_hold,
		rs_low, rs_sda, rs_wait, rs_setup, rs_hold,
		bit_low, bit_wait, bit_high,
		sp_low, sp_cnt, sp_wait, sp_high, sp_rel, sp_done
	} state_e;

	// Status word, top bit first
	typedef struct packed {
		logic busy;
		logic stop_seen;
		logic start_seen;
		logic write_collide_flag;
		logic coll;
		logic event_flag;
	} stat_s;
endpackage

// File: i2c_master_start_rate_gen.sv
`timescale 1ns/10ps
module i2c_master_start_rate_gen (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// Register bus write channels
	input  wire logic [3:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// Register bus read channels
	input  wire logic [3:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Open-drain bus lines
	input  wire logic        scl_in,
	output logic             scl_out,
	output logic             scl_oe,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe
);
	// Bus slave state
	logic              next_awready;
	logic              next_wready;
	logic              next_bvalid;
	logic [1:0]        next_bresp;
	logic              next_arready;
	logic              next_rvalid;
	logic [31:0]       next_rdata;
	logic [1:0]        next_rresp;
	logic [3:0]        waddr;
	logic [3:0]        next_waddr;
	logic [7:0]        wbyte;
	logic [7:0]        next_wbyte;
	logic              wlane;
	logic              next_wlane;
	logic              wr_go;
	// Core state
	logic [7:0]        ctrl;
	logic [7:0]        next_ctrl;
	logic [7:0]        buffer;
	logic [7:0]        next_buffer;
	logic [6:0]        rate;
	logic [6:0]        next_rate;
	i2c_pkg::stat_s    stat;
	i2c_pkg::stat_s    next_stat;
	i2c_pkg::state_e   state;
	i2c_pkg::state_e   next_state;
	logic [6:0]        cnt;
	logic [6:0]        next_cnt;
	logic              run;
	logic              next_run;
	logic [1:0]        phase;
	logic [3:0]        bitn;
	logic [3:0]        next_bitn;
	logic [7:0]        shift;
	logic [7:0]        next_shift;
	logic              tx_mode;
	logic              next_tx_mode;
	logic              next_scl_oe;
	logic              next_sda_oe;
	logic              scl_meta;
	logic              scl_s;
	logic              sda_meta;
	logic              sda_s;
	logic              sda_prev;
	logic              tick;
	logic              expire;
	logic              busy;

	// Two-flop line synchronisers and free-running phase counter
	always_ff @(posedge clk) begin
		if (reset) begin
			scl_meta <= 1'b1;
			scl_s    <= 1'b1;
			sda_meta <= 1'b1;
			sda_s    <= 1'b1;
			sda_prev <= 1'b1;
			phase    <= 2'h0;
			scl_out  <= 1'b0;
			sda_out  <= 1'b0;
		end else begin
			scl_meta <= scl_in;
			scl_s    <= scl_meta;
			sda_meta <= sda_in;
			sda_s    <= sda_meta;
			sda_prev <= sda_s;
			phase    <= phase + 2'h1;
			scl_out  <= 1'b0;
			sda_out  <= 1'b0;
		end
	end

	// Counter pacing and timeout
	assign tick = (phase == i2c_pkg::PHASE_TWO) ||
		(phase == i2c_pkg::PHASE_FOUR);
	assign expire = run && tick && (cnt == 7'h00);
	assign busy = (state != i2c_pkg::st_idle) || (ctrl[3:0] != 4'h0);

	// Write and read channel handshakes, read data mux
	always_comb begin
		next_awready = awready;
		next_wready  = wready;
		next_bvalid  = bvalid;
		next_bresp   = bresp;
		next_arready = arready;
		next_rvalid  = rvalid;
		next_rdata   = rdata;
		next_rresp   = rresp;
		next_waddr   = waddr;
		next_wbyte   = wbyte;
		next_wlane   = wlane;
		wr_go = !awready && !wready && !bvalid;
		if (awvalid && awready) begin
			next_awready = 1'b0;
			next_waddr   = awaddr;
		end
		if (wvalid && wready) begin
			next_wready = 1'b0;
			next_wbyte  = wdata[7:0];
			next_wlane  = wstrb[0];
		end
		if (wr_go) begin
			next_bvalid = 1'b1;
			case (waddr)
				i2c_pkg::OFF_CTRL, i2c_pkg::OFF_BUF,
				i2c_pkg::OFF_RATE, i2c_pkg::OFF_STAT:
					next_bresp = i2c_pkg::RESP_OKAY;
				default: next_bresp = i2c_pkg::RESP_SLVERR;
			endcase
		end
		if (bvalid && bready) begin
			next_bvalid  = 1'b0;
			next_awready = 1'b1;
			next_wready  = 1'b1;
		end
		if (arvalid && arready) begin
			next_arready = 1'b0;
			next_rvalid  = 1'b1;
			next_rresp   = i2c_pkg::RESP_OKAY;
			case (araddr)
				i2c_pkg::OFF_CTRL: next_rdata = {24'h000000, ctrl};
				i2c_pkg::OFF_BUF:  next_rdata = {24'h000000, buffer};
				i2c_pkg::OFF_RATE: next_rdata = {25'h0, rate};
				i2c_pkg::OFF_STAT: next_rdata = {26'h0, stat};
				default: begin
					next_rdata = 32'h00000000;
					next_rresp = i2c_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (rvalid && rready) begin
			next_rvalid  = 1'b0;
			next_arready = 1'b1;
		end
	end

	// Bus slave registers
	always_ff @(posedge clk) begin
		if (reset) begin
			awready <= 1'b1;
			wready  <= 1'b1;
			bvalid  <= 1'b0;
			bresp   <= i2c_pkg::RESP_OKAY;
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h00000000;
			rresp   <= i2c_pkg::RESP_OKAY;
			waddr   <= 4'h0;
			wbyte   <= 8'h00;
			wlane   <= 1'b0;
		end else begin
			awready <= next_awready;
			wready  <= next_wready;
			bvalid  <= next_bvalid;
			bresp   <= next_bresp;
			arready <= next_arready;
			rvalid  <= next_rvalid;
			rdata   <= next_rdata;
			rresp   <= next_rresp;
			waddr   <= next_waddr;
			wbyte   <= next_wbyte;
			wlane   <= next_wlane;
		end
	end

	// Registers, rate counter and bus sequencer
	always_comb begin
		next_ctrl    = ctrl;
		next_buffer  = buffer;
		next_rate    = rate;
		next_stat    = stat;
		next_state   = state;
		next_cnt     = cnt;
		next_run     = run;
		next_bitn    = bitn;
		next_shift   = shift;
		next_tx_mode = tx_mode;
		next_scl_oe  = scl_oe;
		next_sda_oe  = sda_oe;
		// Count down to zero, then hold until reloaded
		if (run && tick && (cnt != 7'h00)) begin
			next_cnt = cnt - 7'h01;
		end
		if (expire) begin
			next_run = 1'b0;
		end
		// Start and stop seen on the lines by anyone
		if (scl_s && sda_prev && !sda_s) begin
			next_stat.start_seen = 1'b1;
			next_stat.stop_seen  = 1'b0;
		end
		if (scl_s && !sda_prev && sda_s) begin
			next_stat.stop_seen  = 1'b1;
			next_stat.start_seen = 1'b0;
		end
		// Software writes
		if (wr_go && wlane) begin
			case (waddr)
				i2c_pkg::OFF_CTRL: begin
					next_ctrl[i2c_pkg::B_ACKDATA] =
						wbyte[i2c_pkg::B_ACKDATA];
					if (!busy) begin
						next_ctrl[4:0] = wbyte[4:0];
					end
				end
				i2c_pkg::OFF_BUF: begin
					if (busy) begin
						next_stat.write_collide_flag = 1'b1;
					end else begin
						next_buffer  = wbyte;
						next_shift   = wbyte;
						next_tx_mode = 1'b1;
						next_bitn    = 4'h0;
						next_scl_oe  = 1'b1;
						next_sda_oe  = !wbyte[7];
						next_cnt     = rate;
						next_run     = 1'b1;
						next_state   = i2c_pkg::bit_low;
					end
				end
				i2c_pkg::OFF_RATE: next_rate = wbyte[6:0];
				i2c_pkg::OFF_STAT: begin
					if (wbyte[0] && i2c_pkg::STAT_W1C[0])
						next_stat.event_flag = 1'b0;
					if (wbyte[1] && i2c_pkg::STAT_W1C[1])
						next_stat.coll = 1'b0;
					if (wbyte[2] && i2c_pkg::STAT_W1C[2])
						next_stat.write_collide_flag = 1'b0;
				end
				default: ;
			endcase
		end
		// Sequencer; hardware sets land after clears so they win
		case (state)
			i2c_pkg::st_idle: begin
				if (ctrl[i2c_pkg::B_START]) begin
					if (scl_s && sda_s) begin
						next_cnt   = rate;
						next_run   = 1'b1;
						next_state = i2c_pkg::st_setup;
					end else if (!scl_s && !sda_s) begin
						next_stat.coll = 1'b1;
						next_ctrl[3:0] = 4'h0;
					end
				end else if (ctrl[i2c_pkg::B_RESTART]) begin
					next_scl_oe = 1'b1;
					next_state  = i2c_pkg::rs_low;
				end else if (ctrl[i2c_pkg::B_STOP]) begin
					next_scl_oe = 1'b1;
					next_sda_oe = 1'b1;
					next_state  = i2c_pkg::sp_low;
				end else if (ctrl[i2c_pkg::B_RECV]) begin
					next_tx_mode = 1'b0;
					next_bitn    = 4'h0;
					next_scl_oe  = 1'b1;
					next_sda_oe  = 1'b0;
					next_cnt     = rate;
					next_run     = 1'b1;
					next_state   = i2c_pkg::bit_low;
				end
			end
			i2c_pkg::st_setup: begin
				if (!scl_s) begin
					next_stat.coll = 1'b1;
					next_ctrl[3:0] = 4'h0;
					next_run       = 1'b0;
					next_state     = i2c_pkg::st_idle;
				end else if (expire) begin
					if (sda_s) begin
						next_sda_oe = 1'b1;
						next_stat.start_seen = 1'b1;
						next_stat.stop_seen  = 1'b0;
						next_cnt   = rate;
						next_run   = 1'b1;
						next_state = i2c_pkg::st_hold;
					end else begin
						next_stat.coll = 1'b1;
						next_ctrl[3:0] = 4'h0;
						next_state     = i2c_pkg::st_idle;
					end
				end
			end
			i2c_pkg::st_hold: begin
				if (expire) begin
					next_ctrl[i2c_pkg::B_START] = 1'b0;
					next_stat.event_flag = 1'b1;
					next_state = i2c_pkg::st_idle;
				end
			end
			i2c_pkg::rs_low: begin
				if (!scl_s) begin
					next_cnt    = {1'b0, rate[5:0]};
					next_run    = 1'b1;
					next_sda_oe = 1'b0;
					next_state  = i2c_pkg::rs_sda;
				end
			end
			i2c_pkg::rs_sda: begin
				if (expire && sda_s) begin
					next_scl_oe = 1'b0;
					next_state  = i2c_pkg::rs_wait;
				end else if (expire) begin
					next_stat.coll = 1'b1;
					next_ctrl[3:0] = 4'h0;
					next_scl_oe    = 1'b0;
					next_state     = i2c_pkg::st_idle;
				end
			end
			i2c_pkg::rs_wait: begin
				if (scl_s && !sda_s) begin
					next_stat.coll = 1'b1;
					next_ctrl[3:0] = 4'h0;
					next_state     = i2c_pkg::st_idle;
				end else if (scl_s) begin
					next_cnt   = rate;
					next_run   = 1'b1;
					next_state = i2c_pkg::rs_setup;
				end
			end
			i2c_pkg::rs_setup: begin
				if (!scl_s) begin
					next_stat.coll = 1'b1;
					next_ctrl[3:0] = 4'h0;
					next_run       = 1'b0;
					next_state     = i2c_pkg::st_idle;
				end else if (expire) begin
					next_sda_oe = 1'b1;
					next_cnt    = rate;
					next_run    = 1'b1;
					next_state  = i2c_pkg::rs_hold;
				end
			end
			i2c_pkg::rs_hold: begin
				if (expire) begin
					next_ctrl[i2c_pkg::B_RESTART] = 1'b0;
					next_stat.event_flag = 1'b1;
					next_state = i2c_pkg::st_idle;
				end
			end
			i2c_pkg::bit_low: begin
				if (expire) begin
					next_scl_oe = 1'b0;
					next_state  = i2c_pkg::bit_wait;
				end
			end
			i2c_pkg::bit_wait: begin
				if (scl_s) begin
					next_cnt   = rate;
					next_run   = 1'b1;
					next_state = i2c_pkg::bit_high;
				end
			end
			i2c_pkg::bit_high: begin
				if (expire) begin
					next_scl_oe = 1'b1;
					if (bitn == i2c_pkg::ACK_SLOT) begin
						if (tx_mode) begin
							next_ctrl[i2c_pkg::B_ACKSTAT] = sda_s;
						end else begin
							next_buffer = shift;
							next_ctrl[i2c_pkg::B_RECV] = 1'b0;
						end
						next_sda_oe = 1'b0;
						next_stat.event_flag = 1'b1;
						next_state = i2c_pkg::st_idle;
					end else begin
						next_shift = {shift[6:0], sda_s};
						next_bitn  = bitn + 4'h1;
						if (bitn + 4'h1 == i2c_pkg::ACK_SLOT) begin
							next_sda_oe = !tx_mode &&
								!ctrl[i2c_pkg::B_ACKDATA];
						end else begin
							next_sda_oe = tx_mode && !shift[6];
						end
						next_cnt   = rate;
						next_run   = 1'b1;
						next_state = i2c_pkg::bit_low;
					end
				end
			end
			i2c_pkg::sp_low: begin
				if (!sda_s) begin
					next_cnt   = rate;
					next_run   = 1'b1;
					next_state = i2c_pkg::sp_cnt;
				end
			end
			i2c_pkg::sp_cnt: begin
				if (expire) begin
					next_scl_oe = 1'b0;
					next_state  = i2c_pkg::sp_wait;
				end
			end
			i2c_pkg::sp_wait: begin
				if (scl_s) begin
					next_cnt   = rate;
					next_run   = 1'b1;
					next_state = i2c_pkg::sp_high;
				end
			end
			i2c_pkg::sp_high: begin
				if (expire) begin
					next_sda_oe = 1'b0;
					next_state  = i2c_pkg::sp_rel;
				end
			end
			i2c_pkg::sp_rel: begin
				if (scl_s && sda_s) begin
					next_cnt   = rate;
					next_run   = 1'b1;
					next_state = i2c_pkg::sp_done;
				end
			end
			i2c_pkg::sp_done: begin
				if (expire) begin
					next_ctrl[i2c_pkg::B_STOP] = 1'b0;
					next_stat.event_flag = 1'b1;
					next_state = i2c_pkg::st_idle;
				end
			end
			default: next_state = i2c_pkg::st_idle;
		endcase
		next_stat.busy = (next_state != i2c_pkg::st_idle) ||
			(next_ctrl[3:0] != 4'h0);
	end

	// Core registers
	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl    <= i2c_pkg::CTRL_RST;
			buffer  <= i2c_pkg::BUF_RST;
			rate    <= i2c_pkg::RATE_RST;
			stat    <= '0;
			state   <= i2c_pkg::st_idle;
			cnt     <= 7'h00;
			run     <= 1'b0;
			bitn    <= 4'h0;
			shift   <= 8'h00;
			tx_mode <= 1'b0;
			scl_oe  <= 1'b0;
			sda_oe  <= 1'b0;
		end else begin
			ctrl    <= next_ctrl;
			buffer  <= next_buffer;
			rate    <= next_rate;
			stat    <= next_stat;
			state   <= next_state;
			cnt     <= next_cnt;
			run     <= next_run;
			bitn    <= next_bitn;
			shift   <= next_shift;
			tx_mode <= next_tx_mode;
			scl_oe  <= next_scl_oe;
			sda_oe  <= next_sda_oe;
		end
	end
endmodule

// File: i2c_master_start_rate_gen_props.sv
`timescale 1ns/10ps
module i2c_master_start_rate_gen_props (
	// Clock and reset
	input wire logic        clk,
	input wire logic        reset,
	// Register bus
	input wire logic [3:0]  awaddr,
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0]  wstrb,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic [1:0]  bresp,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic [3:0]  araddr,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0]  rresp,
	input wire logic        rvalid,
	input wire logic        rready,
	// Bus lines
	input wire logic        scl_in,
	input wire logic        scl_out,
	input wire logic        scl_oe,
	input wire logic        sda_in,
	input wire logic        sda_out,
	input wire logic        sda_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// Pins may only pull low
	chk_pins_low: assert property (!scl_out && !sda_out)
		else $error("bus pin driven high");
	// A released clock stays released for a sync delay and a period
	chk_release_min: assert property ($fell(scl_oe) |-> !scl_oe [*4])
		else $error("clock pulled too soon after release");
	// A clock held low by the far side is waited for
	chk_stretch_wait: assert property ((!scl_oe && !scl_in) [*3] |=> !scl_oe)
		else $error("clock pulled while stretched");
	// Data rising while clock high is a stop; bus stays free
	chk_stop_free: assert property ($fell(sda_oe) && !scl_oe |-> !scl_oe [*4])
		else $error("bus taken right after stop");
	// Data pulled while clock high is held for a period
	chk_start_hold: assert property ($rose(sda_oe) && !scl_oe |-> sda_oe [*4])
		else $error("start data low not held");
	// Bus answers come in time, hold until taken, and block new writes while pending
	chk_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped");
	chk_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer dropped");
	chk_read_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	chk_write_busy: assert property (bvalid |-> !awready && !wready)
		else $error("write taken while answer pending");
	chk_write_answer: assert property (awvalid && awready && wvalid && wready
		|-> ##[1:3] bvalid)
		else $error("write answer late");
endmodule

bind i2c_master_start_rate_gen i2c_master_start_rate_gen_props u_props (
	.clk(clk), .reset(reset), .awaddr(awaddr), .awvalid(awvalid),
	.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
	.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
	.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
	.rresp(rresp), .rvalid(rvalid), .rready(rready), .scl_in(scl_in),
	.scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in),
	.sda_out(sda_out), .sda_oe(sda_oe));

// File: i2c_far_side.sv
`timescale 1ns/10ps
module i2c_far_side (
	// Clock
	input  wire logic       clk,
	// Master pulls
	input  wire logic       scl_oe,
	input  wire logic       sda_oe,
	// Scenario controls
	input  wire logic       nack,
	input  wire logic       stretch,
	input  wire logic       hold_low,
	// Resolved lines and captured byte
	output logic            scl_line,
	output logic            sda_line,
	output logic [7:0]      rx_byte
);
	logic       scl_q;
	logic       sda_q;
	logic       ack_drv;
	logic [3:0] bit_cnt;
	logic [7:0] hold_cnt;

	// Pulled-up lines: any party pulling low wins
	assign scl_line = ~(scl_oe | hold_low | (hold_cnt != 8'h00));
	assign sda_line = ~(sda_oe | hold_low | ack_drv);

	initial begin
		scl_q = 1'b1;
		sda_q = 1'b1;
		ack_drv = 1'b0;
		bit_cnt = 4'h0;
		hold_cnt = 8'h00;
		rx_byte = 8'h00;
	end

	// Bit capture on rising clock, acknowledge and stretch on falling
	always @(posedge clk) begin
		scl_q <= scl_line;
		sda_q <= sda_line;
		if (hold_cnt != 8'h00)
			hold_cnt <= hold_cnt - 8'h01;
		if (scl_line && sda_q && !sda_line)
			bit_cnt <= 4'h0;
		else if (!scl_q && scl_line) begin
			if (bit_cnt != 4'h8)
				rx_byte <= {rx_byte[6:0], sda_line};
			bit_cnt <= (bit_cnt == 4'h9) ? 4'h1 : bit_cnt + 4'h1;
		end
		if (scl_q && !scl_line) begin
			ack_drv <= (bit_cnt == 4'h8) && !nack;
			if (stretch)
				hold_cnt <= 8'hC8;
		end
	end
endmodule

// File: i2c_master_start_rate_gen_tb_top.sv
`timescale 1ns/10ps
module i2c_master_start_rate_gen_tb_top;
	logic        clk, reset, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [3:0]  awaddr, wstrb, araddr;
	logic [31:0] wdata, rdata, rd_d;
	logic [1:0]  bresp, rresp, b_d;
	logic        scl_line, sda_line, scl_out, scl_oe, sda_out, sda_oe;
	logic        nack, stretch, hold_low, rise_sda;
	logic [7:0]  rx_byte;
	int          error_cnt, comparisons, run, high_len;

	i2c_master_start_rate_gen DUT (.clk(clk), .reset(reset),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready),
		.scl_in(scl_line), .scl_out(scl_out), .scl_oe(scl_oe),
		.sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe));
	i2c_far_side far (.clk(clk), .scl_oe(scl_oe), .sda_oe(sda_oe),
		.nack(nack), .stretch(stretch), .hold_low(hold_low),
		.scl_line(scl_line), .sda_line(sda_line), .rx_byte(rx_byte));

	// Clock, length of the last clock-high phase, data at each clock rise
	always #10 clk = ~clk;
	always @(posedge clk) begin
		if (scl_line) begin
			if (run == 0)
				rise_sda <= sda_line;
			run <= run + 1;
		end else begin
			if (run != 0)
				high_len <= run;
			run <= 0;
		end
	end

	task automatic complete_run();
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			error_cnt++;
		end
	endtask

	// Wait for a handshake signal, then step to the taking edge
	task automatic wt(input int s);
		int n;
		for (n = 0; n < 4000; n++) begin
			@(negedge clk);
			if ((s == 0 ? awready & wready : s == 1 ? bvalid :
				s == 2 ? arready : rvalid) === 1'b1)
				break;
		end
		if (n == 4000) begin
			chk(32'h1, 32'h0);
			complete_run();
		end
		@(posedge clk);
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		wt(0);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		wt(1);
		bready <= 1'b1;
		@(posedge clk);
		b_d = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		wt(2);
		arvalid <= 1'b0;
		wt(3);
		rready <= 1'b1;
		@(posedge clk);
		rd_d = rdata;
		rready <= 1'b0;
	endtask

	// Read a register and compare the masked bits
	task automatic cr(input logic [3:0] a, input logic [7:0] m,
		input logic [7:0] e);
		rd(a);
		chk(rd_d & {24'h000000, m}, {24'h000000, e});
	endtask

	// Poll the status register until a masked bit is set
	task automatic wait_stat(input logic [7:0] m);
		int n;
		for (n = 0; n < 1500; n++) begin
			rd(i2c_pkg::OFF_STAT);
			if ((rd_d[7:0] & m) != 8'h00)
				break;
		end
		if (n == 1500) begin
			chk(32'h1, 32'h0);
			complete_run();
		end
	endtask

	initial begin
		{clk, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, nack, stretch, hold_low, b_d} = '0;
		rise_sda = 1'b1;
		{error_cnt, comparisons, run, high_len} = '0;
		wstrb = 4'hF;
		reset = 1'b1;
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		cr(i2c_pkg::OFF_RATE, 8'hFF, 8'h18);
		cr(i2c_pkg::OFF_CTRL, 8'hFF, 8'h00);
		wr(i2c_pkg::OFF_RATE, 8'hFF);
		cr(i2c_pkg::OFF_RATE, 8'hFF, 8'h7F);
		rd(4'h2);
		chk({30'h0, rresp}, {30'h0, i2c_pkg::RESP_SLVERR});
		// Unmapped write answers with an error and changes nothing
		wr(4'h2, 8'h55);
		chk({30'h0, b_d}, {30'h0, i2c_pkg::RESP_SLVERR});
		cr(i2c_pkg::OFF_RATE, 8'hFF, 8'h7F);
		wr(i2c_pkg::OFF_RATE, 8'h20);
		chk({30'h0, b_d}, {30'h0, i2c_pkg::RESP_OKAY});
		// Start, with a buffer write and a stop request refused while it runs
		wr(i2c_pkg::OFF_CTRL, 8'h01);
		wr(i2c_pkg::OFF_BUF, 8'h5A);
		wr(i2c_pkg::OFF_CTRL, 8'h04);
		cr(i2c_pkg::OFF_CTRL, 8'h05, 8'h01);
		wait_stat(8'h01);
		cr(i2c_pkg::OFF_CTRL, 8'h07, 8'h00);
		cr(i2c_pkg::OFF_STAT, 8'h0D, 8'h0D);
		cr(i2c_pkg::OFF_BUF, 8'hFF, 8'h00);
		chk({30'h0, sda_oe, scl_line}, 32'h3);
		wr(i2c_pkg::OFF_STAT, 8'h01);
		cr(i2c_pkg::OFF_STAT, 8'h05, 8'h04);
		wr(i2c_pkg::OFF_STAT, 8'h04);
		// Address byte, acknowledged, clock stretched, restart refused
		stretch <= 1'b1;
		wr(i2c_pkg::OFF_BUF, 8'hA4);
		wr(i2c_pkg::OFF_CTRL, 8'h02);
		wait_stat(8'h01);
		chk({24'h0, rx_byte}, 32'hA4);
		cr(i2c_pkg::OFF_CTRL, 8'h42, 8'h00);
		chk({31'h0, high_len >= 64 && high_len <= 72}, 32'h1);
		chk({31'h0, scl_oe}, 32'h1);
		wr(i2c_pkg::OFF_STAT, 8'h01);
		// Data byte, not acknowledged
		stretch <= 1'b0;
		nack <= 1'b1;
		wr(i2c_pkg::OFF_BUF, 8'h3C);
		wait_stat(8'h01);
		chk({24'h0, rx_byte}, 32'h3C);
		cr(i2c_pkg::OFF_CTRL, 8'h40, 8'h40);
		wr(i2c_pkg::OFF_STAT, 8'h01);
		// Repeated start, then stop
		wr(i2c_pkg::OFF_CTRL, 8'h02);
		wait_stat(8'h01);
		cr(i2c_pkg::OFF_CTRL, 8'h02, 8'h00);
		cr(i2c_pkg::OFF_STAT, 8'h0A, 8'h08);
		chk({30'h0, sda_oe, scl_line}, 32'h3);
		wr(i2c_pkg::OFF_STAT, 8'h01);
		wr(i2c_pkg::OFF_CTRL, 8'h04);
		wait_stat(8'h01);
		cr(i2c_pkg::OFF_CTRL, 8'h04, 8'h00);
		cr(i2c_pkg::OFF_STAT, 8'h10, 8'h10);
		chk({30'h0, sda_line, scl_line}, 32'h3);
		// Receive a byte of released data; master acknowledges it
		wr(i2c_pkg::OFF_STAT, 8'h01);
		wr(i2c_pkg::OFF_CTRL, 8'h08);
		wait_stat(8'h01);
		cr(i2c_pkg::OFF_BUF, 8'hFF, 8'hFF);
		cr(i2c_pkg::OFF_CTRL, 8'h08, 8'h00);
		chk({31'h0, rise_sda}, 32'h0);
		// Start with both lines held low collides
		hold_low <= 1'b1;
		wr(i2c_pkg::OFF_STAT, 8'h07);
		wr(i2c_pkg::OFF_CTRL, 8'h01);
		wait_stat(8'h02);
		cr(i2c_pkg::OFF_CTRL, 8'h01, 8'h00);
		chk({31'h0, sda_oe}, 32'h0);
		hold_low <= 1'b0;
		complete_run();
	end
endmodule
